// [verilog/mbrs_pkg.sv]
package mbrs_pkg;

  // ----------------------------------------
  // Frame fields and function codes
  // ----------------------------------------
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  localparam logic [7:0] FC_READ_HOLD = 8'h03;
  localparam logic [7:0] FC_WRITE_COIL = 8'h05;
  localparam logic [7:0] FC_WRITE_ONE = 8'h06;
  localparam logic [7:0] FC_WRITE_MANY = 8'h10;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_BAD_FUNC = 8'h01;
  localparam logic [7:0] EXC_BAD_ADDR = 8'h02;

  // ----------------------------------------
  // Address spaces
  // ----------------------------------------
  localparam int HR_COUNT = 4;
  localparam logic [15:0] HR_BASE = 16'h00FB;
  localparam logic [16:0] HR_END = 17'h000FF;
  localparam logic [15:0] TD_ADDR = 16'h0122;
  localparam logic [15:0] COMM_OFF_COIL = 16'h0072;
  localparam logic [15:0] COIL_ON = 16'hFF00;

  // Acceptance limits and reset values of the holding registers
  localparam logic [15:0] HR_MIN [HR_COUNT] = '{16'h0001, 16'h0064, 16'h0001, 16'h03E8};
  localparam logic [15:0] HR_MAX [HR_COUNT] = '{16'h05DC, 16'h1388, 16'h05DC, 16'h1388};
  localparam logic [15:0] HR_RST [HR_COUNT] = '{16'h0064, 16'h05DC, 16'h001E, 16'h0DAC};
  localparam logic [15:0] TD_RST = 16'h0000;

  // ----------------------------------------
  // Buffer sizes and frame lengths
  // ----------------------------------------
  localparam int BUF_LEN = 24;
  localparam logic [4:0] MIN_FRAME = 5'h08;
  localparam logic [5:0] EXC_LEN = 6'h03;
  localparam logic [5:0] ECHO_LEN = 6'h06;
  localparam logic [5:0] RD_HDR_LEN = 6'h03;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;

  // Broadcast acceptance selector
  typedef enum logic [1:0] {
    BC_DISABLED = 2'h0,
    BC_ENABLED = 2'h1,
    BC_TIMEDATE = 2'h2
  } mbrs_bcast_e;

  // Request handler states
  typedef enum logic [3:0] {
    S_RX = 4'h1,
    S_CHK = 4'h2,
    S_WR = 4'h4,
    S_TX = 4'h8
  } mbrs_state_e;

endpackage

// [verilog/mbrs_crc16.sv]
`timescale 1ns/1ns
module mbrs_crc16
  import mbrs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic en,
  input wire logic [7:0] data,
  output logic [15:0] crc
);

  logic [15:0] next_crc;

  // Reflected CRC-16 over one byte
  always_comb begin
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    next_crc = crc;
    if (clr) begin
      next_crc = CRC_INIT;
    end else if (en) begin
      next_crc = c;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      crc <= CRC_INIT;
    end else begin
      crc <= next_crc;
    end
  end

endmodule

// [verilog/mbrs_req_handler.sv]
`timescale 1ns/1ns
// Summary of operation
// - Process only good frames for own/zero address
// - Address zero is broadcast, never replied
// - Own-address requests get a reply unless suspended or disabled
// - Bad function or address gives exception
// - Bad data value still gets normal reply
// - Out-of-limit writes dropped, old value kept
// - Reads return value kept after rejection
// - Exception sent at once, request abandoned
// - Multi-write tries every register separately
// - Answer until readdressed, suspended or disabled
// - Keypad selects one of three broadcast modes
// - Enabled mode executes broadcasts, no reply
// - Time mode executes only broadcast time set
// - Addressed time set/check gives address exception
// - No modem handshake lines used
// - Disabled mode ignores all broadcasts
// - Each function limited to its range
module mbrs_req_handler
  import mbrs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] dev_addr,
  input wire logic [1:0] bcast_mode,
  input wire logic link_suspend,
  input wire logic link_resume,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_end,
  input wire logic rx_crc_ok,
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic kp_wr,
  input wire logic [1:0] kp_idx,
  input wire logic [15:0] kp_data,
  output logic comm_disabled,
  output logic [16*HR_COUNT-1:0] hold_regs,
  output logic [15:0] td_value
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  mbrs_state_e state, next_state;
  logic [7:0] rx_buf [BUF_LEN];
  logic [7:0] next_rx_buf [BUF_LEN];
  logic [4:0] rx_cnt, next_rx_cnt;
  logic ovf, next_ovf;
  logic [15:0] hr [HR_COUNT];
  logic [15:0] next_hr [HR_COUNT];
  logic [15:0] next_td_value;
  logic next_comm_disabled;
  logic [7:0] exc_code, next_exc_code;
  logic [5:0] resp_len, next_resp_len;
  logic [5:0] ti, next_ti;
  logic [2:0] wi, next_wi, wq, next_wq;
  logic reply, next_reply;
  logic next_tx_valid;
  logic [7:0] next_tx_data;
  logic [15:0] crc;

  // Request fields, decoded straight from the buffer
  logic [7:0] fc;
  logic [15:0] addr16, val16;
  logic is_bc, for_me, f3, f5, f6, f16, fc_known, td_target;
  logic hr_hit, range_ok, len16_ok, req_ok, bc_accept;

  assign fc = rx_buf[1];
  assign addr16 = {rx_buf[2], rx_buf[3]};
  assign val16 = {rx_buf[4], rx_buf[5]};
  assign is_bc = rx_buf[0] == BCAST_ADDR;
  assign for_me = is_bc || (rx_buf[0] == dev_addr);
  assign f3 = fc == FC_READ_HOLD;
  assign f5 = fc == FC_WRITE_COIL;
  assign f6 = fc == FC_WRITE_ONE;
  assign f16 = fc == FC_WRITE_MANY;
  assign fc_known = f3 || f5 || f6 || f16;
  assign td_target = (addr16 == TD_ADDR) && (f3 || f6 || f16);
  assign hr_hit = (addr16 >= HR_BASE) && ({1'b0, addr16} < HR_END);
  assign range_ok = hr_hit && (val16 != 16'h0000)
    && (({1'b0, addr16} + {1'b0, val16}) <= HR_END);
  assign len16_ok = ({3'h0, rx_cnt} >= (8'h09 + rx_buf[6]))
    && ({1'b0, rx_buf[6]} == {val16[7:0], 1'b0}); // Byte count is twice the quantity
  // Each function reaches only its own address space
  always_comb begin
    unique case (1'b1)
      f3: req_ok = range_ok;
      f5: req_ok = addr16 == COMM_OFF_COIL;
      f6: req_ok = hr_hit || td_target;
      f16: req_ok = (range_ok || (td_target && val16 == 16'h0001)) && len16_ok;
      default: req_ok = 1'b0;
    endcase
  end
  // Broadcast selector set from the keypad
  assign bc_accept = (bcast_mode == BC_ENABLED)
    || ((bcast_mode == BC_TIMEDATE) && td_target && (f6 || f16));

  // Write target and data of the current loop step
  logic [15:0] wr_off, wr_val;
  logic [1:0] wr_idx;
  assign wr_off = addr16 - HR_BASE + {13'h0000, wi};
  assign wr_idx = wr_off[1:0];
  assign wr_val = f6 ? val16 : {rx_buf[7 + 2 * wi], rx_buf[8 + 2 * wi]};

  // Read data word for the response byte at ti
  logic [5:0] rd_k;
  logic [15:0] rd_off, rd_word;
  assign rd_k = ti - RD_HDR_LEN;
  assign rd_off = addr16 - HR_BASE + {11'h000, rd_k[5:1]};
  assign rd_word = hr[rd_off[1:0]];

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_rx_buf = rx_buf;
    next_rx_cnt = rx_cnt;
    next_ovf = ovf;
    next_hr = hr;
    next_td_value = td_value;
    next_comm_disabled = comm_disabled;
    next_exc_code = exc_code;
    next_resp_len = resp_len;
    next_ti = ti;
    next_wi = wi;
    next_wq = wq;
    next_reply = reply;
    next_tx_valid = tx_valid;
    next_tx_data = tx_data;
    // Keypad writes pass the same limit check as link writes
    if (kp_wr && state != S_WR) begin
      if (kp_data >= HR_MIN[kp_idx] && kp_data <= HR_MAX[kp_idx]) begin
        next_hr[kp_idx] = kp_data;
      end
    end
    if (link_resume) begin
      next_comm_disabled = 1'b0;
    end
    unique case (state)
      S_RX: begin
        if (rx_valid) begin
          if (rx_cnt < 5'(BUF_LEN)) begin
            next_rx_buf[rx_cnt] = rx_data;
            next_rx_cnt = rx_cnt + 5'h01;
          end else begin
            next_ovf = 1'b1;
          end
        end
        if (rx_end) begin
          if (rx_crc_ok && !ovf && rx_cnt >= MIN_FRAME) begin
            next_state = S_CHK;
          end else begin
            next_rx_cnt = '0;
          end
          next_ovf = 1'b0;
        end
      end
      S_CHK: begin
        next_state = S_RX;
        next_rx_cnt = '0;
        next_ti = '0;
        next_wi = '0;
        next_reply = !is_bc;
        next_exc_code = EXC_NONE;
        if (for_me && !comm_disabled && !link_suspend) begin
          if (is_bc && !(bc_accept && req_ok)) begin
            next_state = S_RX;
          end else if (!is_bc && !fc_known) begin
            next_exc_code = EXC_BAD_FUNC;
            next_resp_len = EXC_LEN;
            next_state = S_TX;
          end else if (!is_bc && (!req_ok || td_target)) begin
            next_exc_code = EXC_BAD_ADDR;
            next_resp_len = EXC_LEN;
            next_state = S_TX;
          end else if (f3) begin
            next_resp_len = RD_HDR_LEN + {val16[4:0], 1'b0};
            next_state = is_bc ? S_RX : S_TX;
          end else if (f5) begin
            if (val16 == COIL_ON) begin
              next_comm_disabled = 1'b1;
            end
            next_resp_len = ECHO_LEN;
            next_state = is_bc ? S_RX : S_TX;
          end else begin
            next_wq = f6 ? 3'h1 : val16[2:0];
            next_resp_len = ECHO_LEN;
            next_state = S_WR;
          end
        end
      end
      S_WR: begin
        // One register per cycle; a rejected value leaves the rest going
        if (td_target) begin
          next_td_value = wr_val;
        end else if (wr_val >= HR_MIN[wr_idx] && wr_val <= HR_MAX[wr_idx]) begin
          next_hr[wr_idx] = wr_val;
        end
        next_wi = wi + 3'h1;
        if (wi + 3'h1 >= wq) begin
          next_state = reply ? S_TX : S_RX;
        end
      end
      S_TX: begin
        if (tx_valid) begin
          if (tx_ready) begin
            next_tx_valid = 1'b0;
            next_ti = ti + 6'h01;
          end
        end else if (ti < resp_len) begin
          next_tx_valid = 1'b1;
          if (exc_code != EXC_NONE) begin
            unique case (ti)
              6'h00: next_tx_data = rx_buf[0];
              6'h01: next_tx_data = fc | EXC_FLAG;
              default: next_tx_data = exc_code;
            endcase
          end else if (f3) begin
            if (ti == 6'h00 || ti == 6'h01) begin
              next_tx_data = rx_buf[ti[0]];
            end else if (ti == 6'h02) begin
              next_tx_data = {val16[6:0], 1'b0};
            end else begin
              next_tx_data = rd_k[0] ? rd_word[7:0] : rd_word[15:8];
            end
          end else begin
            next_tx_data = rx_buf[ti[4:0]];
          end
        end else if (ti == resp_len) begin
          next_tx_valid = 1'b1;
          next_tx_data = crc[7:0];
        end else if (ti == resp_len + 6'h01) begin
          next_tx_valid = 1'b1;
          next_tx_data = crc[15:8];
        end else begin
          next_state = S_RX;
        end
      end
      default: begin
        next_state = S_RX;
      end
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= S_RX;
      rx_buf <= '{default: 8'h00};
      rx_cnt <= '0;
      ovf <= 1'b0;
      hr <= HR_RST;
      td_value <= TD_RST;
      comm_disabled <= 1'b0;
      exc_code <= EXC_NONE;
      resp_len <= '0;
      ti <= '0;
      wi <= '0;
      wq <= '0;
      reply <= 1'b0;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
    end else begin
      state <= next_state;
      rx_buf <= next_rx_buf;
      rx_cnt <= next_rx_cnt;
      ovf <= next_ovf;
      hr <= next_hr;
      td_value <= next_td_value;
      comm_disabled <= next_comm_disabled;
      exc_code <= next_exc_code;
      resp_len <= next_resp_len;
      ti <= next_ti;
      wi <= next_wi;
      wq <= next_wq;
      reply <= next_reply;
      tx_valid <= next_tx_valid;
      tx_data <= next_tx_data;
    end
  end

  // Flattened register view, straight from the flops
  genvar g;
  generate
    for (g = 0; g < HR_COUNT; g++) begin : g_hr
      assign hold_regs[16 * g +: 16] = hr[g];
    end
  endgenerate

  // ----------------------------------------
  // Response CRC, fed with each data byte as it leaves
  // ----------------------------------------
  mbrs_crc16 u_crc (
    .ref_clk(ref_clk),
    .rst(rst),
    .clr(state == S_CHK),
    .en(state == S_TX && tx_valid && tx_ready && ti < resp_len),
    .data(tx_data),
    .crc(crc)
  );

  // The link carries only data; no modem handshake lines exist here

endmodule

// [tb/mbrs_req_handler_checker.sv]
`timescale 1ns/1ns
module mbrs_req_handler_checker
  import mbrs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] dev_addr,
  input wire logic [1:0] bcast_mode,
  input wire logic link_suspend,
  input wire logic link_resume,
  input wire logic rx_end,
  input wire logic rx_crc_ok,
  input wire logic tx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic kp_wr,
  input wire logic [1:0] kp_idx,
  input wire logic [15:0] kp_data,
  input wire logic comm_disabled,
  input wire logic [16*HR_COUNT-1:0] hold_regs,
  input wire logic [15:0] td_value
);
  logic in_lim;

  // Every holding register inside its limits
  always_comb begin
    in_lim = 1'b1;
    for (int i = 0; i < HR_COUNT; i++) begin
      if (hold_regs[16*i+:16] < HR_MIN[i] || hold_regs[16*i+:16] > HR_MAX[i]) begin
        in_lim = 1'b0;
      end
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Reply handshake, reply address, dropped frames, link resume
  property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
  a_hold: assert property (p_hold) else $error("tx byte lost");
  property p_gap; tx_valid && tx_ready |=> !tx_valid; endproperty
  a_gap: assert property (p_gap) else $error("tx gap missing");
  property p_first;
    $rose(tx_valid) && !$past(tx_valid, 2) |-> tx_data == dev_addr && dev_addr != BCAST_ADDR;
  endproperty
  a_first: assert property (p_first) else $error("reply address wrong");
  property p_drop; rx_end && (!rx_crc_ok || link_suspend || comm_disabled) |=> !tx_valid [*4];
  endproperty
  a_drop: assert property (p_drop) else $error("dropped frame answered");
  property p_resume; link_resume |=> !comm_disabled; endproperty
  a_resume: assert property (p_resume) else $error("link not resumed");
  // Stored values and broadcast effects
  property p_lim; in_lim; endproperty
  a_lim: assert property (p_lim) else $error("register out of limits");
  property p_td; !$stable(td_value) |-> bcast_mode inside {BC_ENABLED, BC_TIMEDATE}; endproperty
  a_td: assert property (p_td) else $error("time set in disabled mode");
  property p_kp;
    kp_wr && kp_idx == 2'h0 && kp_data >= HR_MIN[0] && kp_data <= HR_MAX[0]
      |=> hold_regs[15:0] == $past(kp_data);
  endproperty
  a_kp: assert property (p_kp) else $error("keypad write lost");
endmodule

bind mbrs_req_handler mbrs_req_handler_checker i_chk (
  .ref_clk(ref_clk), .rst(rst), .dev_addr(dev_addr), .bcast_mode(bcast_mode),
  .link_suspend(link_suspend), .link_resume(link_resume), .rx_end(rx_end),
  .rx_crc_ok(rx_crc_ok), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
  .kp_wr(kp_wr), .kp_idx(kp_idx), .kp_data(kp_data), .comm_disabled(comm_disabled),
  .hold_regs(hold_regs), .td_value(td_value)
);

// [tb/mbrs_master.sv]
`timescale 1ns/1ns
module mbrs_master (
  input wire logic ref_clk,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_end,
  output logic rx_crc_ok
);
  logic slow = 1'b0;
  logic ok_q = 1'b0;
  logic [7:0] cur = 8'h00;
  logic [7:0] junk = 8'h00;
  logic [7:0] got [$];

  // Lines carry a changing pattern when not qualified
  assign rx_data = rx_valid ? cur : junk;
  assign rx_crc_ok = rx_end ? ok_q : junk[0];

  // Collect reply bytes, stall at random when slow
  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_end = 1'b0;
  end
  always @(posedge ref_clk) begin
    if (tx_valid && tx_ready) got.push_back(tx_data);
    tx_ready <= !slow || ($urandom_range(3) == 0);
    junk <= junk + 8'h5B;
  end

  // One frame, then the end pulse with the CRC verdict
  task automatic send(input logic [7:0] f [$], input logic ok);
    foreach (f[i]) begin
      rx_valid <= 1'b1;
      cur <= f[i];
      @(posedge ref_clk);
    end
    rx_valid <= 1'b0;
    rx_end <= 1'b1;
    ok_q <= ok;
    @(posedge ref_clk);
    rx_end <= 1'b0;
  endtask
endmodule

// [tb/mbrs_req_handler_tb.sv]
`timescale 1ns/1ns
module mbrs_req_handler_tb
  import mbrs_pkg::*;
;
  typedef logic [7:0] mbrs_q8_t [$];
  logic ref_clk, rst, link_suspend, link_resume, kp_wr, rx_valid, rx_end, rx_crc_ok;
  logic tx_ready, tx_valid, comm_disabled;
  logic [7:0] dev_addr, rx_data, tx_data;
  logic [1:0] bcast_mode, kp_idx, idx;
  logic [15:0] kp_data, td_value, v, tdm;
  logic [16*HR_COUNT-1:0] hold_regs;
  logic [15:0] m [HR_COUNT];
  logic [7:0] tfc [9] = '{8'h01, 8'h04, 8'h03, 8'h03, 8'h05, 8'h06, 8'h03, 8'h06, 8'h10};
  logic [15:0] tad [9] = '{16'h00FB, 16'h00FB, 16'h0100, 16'h00FC, 16'h00FB, 16'h0072,
    16'h0122, 16'h0122, 16'h0122};
  mbrs_q8_t f, nil;
  int fails = 0;
  int compares = 0;

  mbrs_req_handler i_dut (.ref_clk(ref_clk), .rst(rst), .dev_addr(dev_addr),
    .bcast_mode(bcast_mode), .link_suspend(link_suspend), .link_resume(link_resume),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end), .rx_crc_ok(rx_crc_ok),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .kp_wr(kp_wr),
    .kp_idx(kp_idx), .kp_data(kp_data), .comm_disabled(comm_disabled),
    .hold_regs(hold_regs), .td_value(td_value));
  mbrs_master i_mst (.ref_clk(ref_clk), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end),
    .rx_crc_ok(rx_crc_ok));

  // Frame building and limit checking
  function automatic mbrs_q8_t fin(input mbrs_q8_t q);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    return {q, c[7:0], c[15:8]};
  endfunction
  function automatic mbrs_q8_t req(input logic [7:0] a, fc, input logic [15:0] r, d);
    return fin({a, fc, r[15:8], r[7:0], d[15:8], d[7:0]});
  endfunction
  function automatic logic okv(input logic [1:0] i, input logic [15:0] d);
    return d >= HR_MIN[i] && d <= HR_MAX[i];
  endfunction

  // Compare, transfer and verdict
  task automatic check(input string nm, input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic run(input mbrs_q8_t q, e, input logic ok = 1'b1);
    i_mst.got.delete();
    i_mst.slow <= 1'($urandom_range(1));
    i_mst.send(q, ok);
    for (int n = 0; n < 400 && i_mst.got.size() < e.size(); n++) @(posedge ref_clk);
    repeat (12) @(posedge ref_clk);
    check("reply length", 16'(i_mst.got.size()), 16'(e.size()));
    foreach (e[i]) if (i < i_mst.got.size()) check("reply byte", i_mst.got[i], e[i]);
  endtask
  task automatic rd(input logic drop = 1'b0);
    mbrs_q8_t e;
    e = {dev_addr, FC_READ_HOLD, 8'h08};
    foreach (m[i]) e = {e, m[i][15:8], m[i][7:0]};
    run(req(dev_addr, FC_READ_HOLD, HR_BASE, 16'h0004), drop ? nil : fin(e));
  endtask
  task automatic print_verdict();
    if (fails == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Clock and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (50000) @(posedge ref_clk);
    fails++;
    print_verdict();
  end

  // Main sequence
  initial begin
    void'($urandom(32'hd671));
    rst = 1'b1;
    dev_addr = 8'h11;
    bcast_mode = 2'h0;
    link_suspend = 1'b0;
    link_resume = 1'b0;
    kp_wr = 1'b0;
    kp_idx = 2'h0;
    kp_data = 16'h0000;
    tdm = TD_RST;
    foreach (m[i]) m[i] = HR_RST[i];
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd();
    for (int k = 0; k < 12; k++) begin
      idx = 2'($urandom_range(3));
      v = k < 2 ? HR_MAX[idx] + 16'(k) : 16'($urandom_range(16'h1400));
      f = req(dev_addr, FC_WRITE_ONE, HR_BASE + 16'(idx), v);
      run(f, f);
      if (okv(idx, v)) m[idx] = v;
      rd();
    end
    f = fin({dev_addr, FC_WRITE_MANY, HR_BASE[15:8], HR_BASE[7:0], 8'h00, 8'h04, 8'h08,
      8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h20, 8'h0F, 8'hA0});
    run(f, fin(f[0:5]));
    m[0] = 16'h0010;
    m[2] = 16'h0020;
    m[3] = 16'h0FA0;
    rd();
    for (int md = 0; md < 4; md++) begin
      bcast_mode <= md[1:0];
      for (int k = 0; k < 9; k++) begin
        run(req(dev_addr, tfc[k], tad[k], 16'h0004),
          fin({dev_addr, tfc[k] | EXC_FLAG, k < 2 ? EXC_BAD_FUNC : EXC_BAD_ADDR}));
      end
      check("time after exception", td_value, tdm);
      v = 16'($urandom_range(16'hFFFF));
      run(req(BCAST_ADDR, FC_WRITE_ONE, TD_ADDR, v), nil);
      if (md inside {1, 2}) tdm = v;
      check("time value", td_value, tdm);
      v = v ^ 16'h5A5A;
      run(fin({BCAST_ADDR, FC_WRITE_MANY, TD_ADDR[15:8], TD_ADDR[7:0], 8'h00, 8'h01, 8'h02,
        v[15:8], v[7:0]}), nil);
      if (md inside {1, 2}) tdm = v;
      check("time value multi", td_value, tdm);
      v = m[0] == 16'h0064 ? 16'h0065 : 16'h0064;
      run(req(BCAST_ADDR, FC_WRITE_ONE, HR_BASE, v), nil);
      if (md == 1) m[0] = v;
      check("broadcast write", hold_regs[15:0], m[0]);
    end
    run(req(dev_addr + 8'h01, FC_READ_HOLD, HR_BASE, 16'h0001), nil);
    run(req(dev_addr, FC_READ_HOLD, HR_BASE, 16'h0001), nil, 1'b0);
    link_suspend <= 1'b1;
    rd(1'b1);
    link_suspend <= 1'b0;
    f = req(dev_addr, FC_WRITE_COIL, COMM_OFF_COIL, COIL_ON);
    run(f, f);
    check("comm disabled", 16'(comm_disabled), 16'h0001);
    rd(1'b1);
    link_resume <= 1'b1;
    @(posedge ref_clk);
    link_resume <= 1'b0;
    rd();
    check("comm enabled", 16'(comm_disabled), 16'h0000);
    dev_addr <= 8'h2A;
    @(posedge ref_clk);
    run(req(8'h11, FC_READ_HOLD, HR_BASE, 16'h0001), nil);
    rd();
    for (int k = 0; k < 8; k++) begin
      idx = 2'(k);
      v = k < 4 ? HR_MIN[idx] : HR_MIN[idx] - 16'h0001;
      kp_wr <= 1'b1;
      kp_idx <= idx;
      kp_data <= v;
      @(posedge ref_clk);
      kp_wr <= 1'b0;
      @(posedge ref_clk);
      if (okv(idx, v)) m[idx] = v;
      check("keypad write", hold_regs[16*idx+:16], m[idx]);
    end
    rd();
    print_verdict();
  end
endmodule
